// file: bench/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
   // bench control
   input  wire logic       sys_clk,
   input  wire logic       restart,
   input  wire logic       clientGo,
   input  wire logic       clkPol,
   input  wire logic       nine,
   input  wire logic [8:0] word0,
   // pins
   input  wire logic       clockOut,
   input  wire logic       clockOe_n,
   input  wire logic       dataOut,
   input  wire logic       dataOe_n,
   output logic            dataIn,
   output logic            clockIn
);
   logic       lastClk = 1'b0;
   logic       bitVal  = 1'b0;
   logic [3:0] bitIdx  = 4'h0;
   logic [8:0] nChars  = 9'h0;
   logic [8:0] curWord;
   logic       extClk  = 1'b0;
   logic [2:0] divCnt  = 3'h0;
   logic [5:0] halves  = 6'h00;
   // client mode: one clock per data bit for three characters, then idle
   always @(posedge sys_clk) begin
      divCnt <= divCnt + 3'h1;
      if (restart) begin
         extClk <= clkPol;
         halves <= clientGo ? 6'h30 : 6'h00;
      end else if (divCnt == 3'h7 && halves != 6'h00) begin
         extClk <= ~extClk;
         halves <= halves - 6'h01;
      end
   end
   // each character is word0 plus its index
   assign curWord = word0 + nChars;
   // wire levels resolved from both drivers
   assign clockIn = clockOe_n ? extClk : clockOut;
   assign dataIn  = dataOe_n ? bitVal : dataOut;
   // bit on leading edge, lsb first, advance on trailing edge
   always @(posedge sys_clk) begin
      lastClk <= clockIn;
      if (restart) begin
         bitIdx <= 4'h0;
         nChars <= 9'h0;
      end else if (clockIn != lastClk && clockIn != clkPol) begin
         bitVal <= curWord[bitIdx];
      end else if (clockIn != lastClk) begin
         if (bitIdx == (nine ? 4'h8 : 4'h7)) begin
            bitIdx <= 4'h0;
            nChars <= nChars + 9'h1;
            bitVal <= ~bitVal; // line not held after a character
         end else begin
            bitIdx <= bitIdx + 4'h1;
         end
      end
   end
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import sync_serial_pkg::*;
   logic              sys_clk   = 1'b0;
   logic              reset     = 1'b1;
   logic [ADDR_W-1:0] regAddr   = '0;
   logic [DATA_W-1:0] regWrData = '0;
   logic              regWr     = 1'b0;
   logic              regRd     = 1'b0;
   logic              rdSeen    = 1'b0;
   logic              restart   = 1'b0;
   logic              clientGo  = 1'b0;
   logic              clkPol    = 1'b0;
   logic              nine      = 1'b0;
   logic [8:0]        word0     = 9'h0;
   logic [DATA_W-1:0] regRdData;
   logic              dataIn, dataOut, dataOe_n, clockIn, clockOut, clockOe_n;
   logic              receiveFlag, transmitFlag, wakeRequest;
   logic [DATA_W-1:0] expQ [$];
   int                failures = 0;
   int                total_checks = 0;
   int                seed = 32'h4c32;
   int                p;
   // clock
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   sync_serial_receive_and_client u_dut (.sys_clk(sys_clk), .reset(reset),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
      .clockIn(clockIn), .clockOut(clockOut), .clockOe_n(clockOe_n),
      .receiveFlag(receiveFlag), .transmitFlag(transmitFlag), .wakeRequest(wakeRequest));
   serial_peer u_peer (.sys_clk(sys_clk), .restart(restart), .clkPol(clkPol), .nine(nine),
      .word0(word0), .clockOut(clockOut), .clockOe_n(clockOe_n), .dataOut(dataOut),
      .dataOe_n(dataOe_n), .dataIn(dataIn), .clockIn(clockIn), .clientGo(clientGo));
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      if (failures == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge sys_clk);
      expQ.push_back(e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
   endtask
   task automatic waitRx();
      int n;
      n = 0;
      while (receiveFlag !== 1'b1 && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 2000) begin
         failures++;
         results();
      end
   endtask
   // read data watcher: oldest note against the answer
   always @(posedge sys_clk) begin
      rdSeen <= regRd;
      if (rdSeen) check("regRdData", {1'b0, regRdData}, {1'b0, expQ.pop_front()});
   end
   // main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      rd(RECEIVE_STATUS_OFS, REG_RESET);
      rd(WAKE_CONTROL_OFS, REG_RESET);
      rd(TRANSMIT_DATA_OFS, 8'h00);
      // single receive, both clock polarities
      for (p = 0; p < 2; p++) begin
         word0 <= 9'($random(seed));
         clkPol <= p[0];
         wr(BAUD_CONTROL_OFS, {3'h0, p[0], 4'h0});
         restart <= 1'b1;
         wr(BAUD_DIV_LOW_OFS, 8'h07);
         restart <= 1'b0;
         wr(TRANSMIT_STATUS_OFS, 8'h90);
         wr(RECEIVE_STATUS_OFS, 8'h80);
         repeat (2) @(posedge sys_clk);
         check("clockOe_n", clockOe_n, 9'h0);
         wr(RECEIVE_STATUS_OFS, 8'ha0);
         waitRx();
         repeat (100) @(posedge sys_clk);
         check("clockOut", clockOut, {8'h0, p[0]});
         rd(RECEIVE_STATUS_OFS, 8'h80);
         rd(RECEIVE_DATA_OFS, word0[7:0]);
         repeat (3) @(posedge sys_clk);
         check("receiveFlag", receiveFlag, 9'h0);
      end
      // continuous nine-bit receive into overrun
      restart <= 1'b1;
      wr(RECEIVE_STATUS_OFS, 8'hc0);
      restart <= 1'b0;
      nine <= 1'b1;
      wr(RECEIVE_STATUS_OFS, 8'hd0);
      repeat (700) @(posedge sys_clk);
      rd(RECEIVE_STATUS_OFS, {7'h69, word0[8]});
      rd(RECEIVE_DATA_OFS, word0[7:0]);
      rd(RECEIVE_STATUS_OFS, {7'h69, 1'(9'(word0 + 9'h1) >> 8)});
      rd(RECEIVE_DATA_OFS, 8'(word0 + 9'h1));
      repeat (300) @(posedge sys_clk);
      check("receiveFlag", receiveFlag, 9'h0);
      restart <= 1'b1;
      wr(RECEIVE_STATUS_OFS, 8'hc0);
      restart <= 1'b0;
      wr(RECEIVE_STATUS_OFS, 8'he0);
      waitRx();
      rd(RECEIVE_STATUS_OFS, {7'h60, word0[8]});
      rd(RECEIVE_DATA_OFS, word0[7:0]);
      // transmit mode: empty buffer raises wake request
      wr(RECEIVE_STATUS_OFS, 8'h80);
      wr(TRANSMIT_STATUS_OFS, 8'hb0);
      wr(WAKE_CONTROL_OFS, 8'h03);
      repeat (4) @(posedge sys_clk);
      check("dataOe_n", dataOe_n, 9'h0);
      check("transmitFlag", transmitFlag, 9'h1);
      check("wakeRequest", wakeRequest, 9'h1);
      wr(WAKE_CONTROL_OFS, 8'h01);
      repeat (3) @(posedge sys_clk);
      check("wakeRequest", wakeRequest, 9'h0);
      // two words back to back: the second waits in the holding buffer
      wr(TRANSMIT_DATA_OFS, 8'h5a);
      wr(TRANSMIT_DATA_OFS, 8'hc3);
      repeat (2) @(posedge sys_clk);
      check("transmitFlag", transmitFlag, 9'h0);
      repeat (400) @(posedge sys_clk);
      check("transmitFlag", transmitFlag, 9'h1);
      check("dataOut", dataOut, 9'h1);
      // client single receive: peer clocks three characters into overrun
      nine <= 1'b0;
      wr(TRANSMIT_STATUS_OFS, 8'h10);
      wr(RECEIVE_STATUS_OFS, 8'ha0);
      clientGo <= 1'b1;
      restart <= 1'b1;
      @(posedge sys_clk);
      restart <= 1'b0;
      repeat (500) @(posedge sys_clk);
      check("clockOe_n", clockOe_n, 9'h1);
      rd(RECEIVE_STATUS_OFS, 8'ha2);
      rd(RECEIVE_DATA_OFS, word0[7:0]);
      rd(RECEIVE_STATUS_OFS, 8'ha0);
      rd(RECEIVE_DATA_OFS, 8'(word0 + 9'h1));
      repeat (3) @(posedge sys_clk);
      results();
   end
endmodule

// file: hdl/sync_serial_pkg.sv
package sync_serial_pkg;
   // register bus geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] BAUD_CONTROL_OFS    = 3'h0;
   localparam logic [ADDR_W-1:0] RECEIVE_DATA_OFS    = 3'h1;
   localparam logic [ADDR_W-1:0] RECEIVE_STATUS_OFS  = 3'h2;
   localparam logic [ADDR_W-1:0] BAUD_DIV_LOW_OFS    = 3'h3;
   localparam logic [ADDR_W-1:0] BAUD_DIV_HIGH_OFS   = 3'h4;
   localparam logic [ADDR_W-1:0] TRANSMIT_STATUS_OFS = 3'h5;
   localparam logic [ADDR_W-1:0] TRANSMIT_DATA_OFS   = 3'h6;
   localparam logic [ADDR_W-1:0] WAKE_CONTROL_OFS    = 3'h7;

   // baud control fields
   localparam int RX_IDLE_BIT       = 6;
   localparam int DATA_POL_BIT      = 5;
   localparam int CLOCK_POL_BIT     = 4;
   localparam int DIV16_BIT         = 3;
   // receive status and control fields
   localparam int PORT_ENABLE_BIT   = 7;
   localparam int RX_NINE_BIT       = 6;
   localparam int SINGLE_RX_BIT     = 5;
   localparam int CONT_RX_BIT       = 4;
   localparam int OVERRUN_BIT       = 1;
   localparam int RX_NINTH_DATA_BIT = 0;
   // transmit status and control fields
   localparam int CLOCK_SOURCE_BIT  = 7;
   localparam int TX_NINE_BIT       = 6;
   localparam int TX_ENABLE_BIT     = 5;
   localparam int SYNC_MODE_BIT     = 4;
   localparam int TX_EMPTY_BIT      = 1;
   localparam int TX_NINTH_DATA_BIT = 0;
   // wake control fields
   localparam int PERIPH_IE_BIT     = 0;
   localparam int TX_IE_BIT         = 1;
   localparam int RX_IE_BIT         = 2;
   localparam int TX_FLAG_BIT       = 4;
   localparam int RX_FLAG_BIT       = 5;

   // reset values
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

   // character lengths and fifo geometry
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE  = 4'h9;
   localparam int         FIFO_DEPTH = 2;
   localparam logic [1:0] FIFO_FULL  = 2'h2;
endpackage

// file: hdl/sync_serial_receive_and_client.sv
`timescale 1ns/1ps
module sync_serial_receive_and_client (
   // clock and reset
   input  wire logic                               sys_clk,
   input  wire logic                               reset,
   // register port
   input  wire logic [sync_serial_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [sync_serial_pkg::DATA_W-1:0] regWrData,
   input  wire logic                               regWr,
   input  wire logic                               regRd,
   output logic      [sync_serial_pkg::DATA_W-1:0] regRdData,
   // serial data pin
   input  wire logic                               dataIn,
   output logic                                    dataOut,
   output logic                                    dataOe_n,
   // shift clock pin
   input  wire logic                               clockIn,
   output logic                                    clockOut,
   output logic                                    clockOe_n,
   // status
   output logic                                    receiveFlag,
   output logic                                    transmitFlag,
   output logic                                    wakeRequest
);
   import sync_serial_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   logic [DATA_W-1:0] baudCtl_q, rxCtl_q, txCtl_q, divLow_q, divHigh_q, wakeCtl_q;
   logic [DATA_W-1:0] txBuf_q, rdData_q;
   logic              txBufFull_q, tsrBusy_q;
   logic [8:0]        tsr_q;
   logic [3:0]        txLeft_q;
   logic [8:0]        fifoMem [FIFO_DEPTH];
   logic              rdPtr_q;
   logic [1:0]        fifoCount_q, fifoCount_d;
   logic              overrun_error_q, oerrSingle_q;
   logic [8:0]        rxShift_q;
   logic [3:0]        rxCnt_q;
   logic [2:0]        ckSync_q, dtSync_q;
   logic              ckF_q, ckFd_q, dtF_q;
   logic [15:0]       baudCnt_q;
   logic              ckPhase_q, ckLevel_q;
   logic              dtOut_q, dtOe_n_q, ckOe_n_q, rxFlag_q, txFlag_q, wake_q;

   // mode decode
   logic portOn, syncOn, hostMode, clientMode, rxReq, txMode;
   logic cpol, dpol, nineRx, nineTx;
   assign portOn     = rxCtl_q[PORT_ENABLE_BIT];
   assign syncOn     = txCtl_q[SYNC_MODE_BIT];
   assign hostMode   = portOn && syncOn && txCtl_q[CLOCK_SOURCE_BIT];
   assign clientMode = portOn && syncOn && !txCtl_q[CLOCK_SOURCE_BIT];
   assign rxReq      = rxCtl_q[SINGLE_RX_BIT] || rxCtl_q[CONT_RX_BIT];
   assign txMode     = portOn && syncOn && !rxReq && txCtl_q[TX_ENABLE_BIT];
   assign cpol       = baudCtl_q[CLOCK_POL_BIT];
   assign dpol       = baudCtl_q[DATA_POL_BIT];
   assign nineRx     = rxCtl_q[RX_NINE_BIT];
   assign nineTx     = txCtl_q[TX_NINE_BIT];

   // host run conditions and baud tick
   logic rxRun, txRun, hostRun, tick;
   logic [15:0] divisor;
   assign rxRun   = portOn && syncOn && rxReq && !overrun_error_q;
   assign txRun   = txMode && tsrBusy_q;
   assign hostRun = hostMode && (rxRun || txRun);
   assign divisor = baudCtl_q[DIV16_BIT] ? {divHigh_q, divLow_q} : {8'h00, divLow_q};
   assign tick    = hostRun && (baudCnt_q == 16'h0000);

   // edges: host from own clock, client from filtered pin
   logic hostLead, hostTrail, ckChange, clientLead, clientTrail, leadEdge, trailEdge;
   assign hostLead    = tick && !ckPhase_q;
   assign hostTrail   = tick && ckPhase_q;
   assign ckChange    = clientMode && (ckF_q != ckFd_q);
   assign clientLead  = ckChange && (ckF_q != cpol);
   assign clientTrail = ckChange && (ckF_q == cpol);
   assign leadEdge    = hostMode ? hostLead : clientLead;
   assign trailEdge   = hostMode ? hostTrail : clientTrail;

   // receive sampling and character completion
   logic       sample, rxBit, charDone, push, overrunSet, pop, rcRead;
   logic [3:0] rxBits;
   logic [8:0] rxNext, rxChar;
   assign sample     = rxRun && trailEdge;
   assign rxBit      = dtF_q ^ dpol;
   assign rxBits     = nineRx ? BITS_NINE : BITS_EIGHT;
   assign rxNext     = {rxBit, rxShift_q[8:1]};
   assign rxChar     = nineRx ? rxNext : {1'b0, rxNext[8:1]};
   assign charDone   = sample && (rxCnt_q + 4'h1 == rxBits);
   assign push       = charDone && (fifoCount_q != FIFO_FULL);
   assign overrunSet = charDone && (fifoCount_q == FIFO_FULL);
   assign rcRead     = regRd && hit(regAddr, RECEIVE_DATA_OFS);
   assign pop        = rcRead && (fifoCount_q != 2'h0);

   // pin synchronisers, three stages with agreement filter
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ckSync_q <= 3'h0;
         dtSync_q <= 3'h0;
         ckF_q    <= 1'b0;
         ckFd_q   <= 1'b0;
         dtF_q    <= 1'b0;
      end else begin
         ckSync_q <= {ckSync_q[1:0], clockIn};
         dtSync_q <= {dtSync_q[1:0], dataIn};
         if (ckSync_q[1] == ckSync_q[2]) begin
            ckF_q <= ckSync_q[2];
         end
         if (dtSync_q[1] == dtSync_q[2]) begin
            dtF_q <= dtSync_q[2];
         end
         ckFd_q <= ckF_q;
      end
   end

   // software registers; single enable clears itself after a character in host mode only
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         baudCtl_q <= REG_RESET;
         rxCtl_q   <= REG_RESET;
         txCtl_q   <= REG_RESET;
         divLow_q  <= REG_RESET;
         divHigh_q <= REG_RESET;
         wakeCtl_q <= REG_RESET;
      end else begin
         if (hostMode && charDone) begin
            rxCtl_q[SINGLE_RX_BIT] <= 1'b0;
         end
         if (regWr) begin
            if (hit(regAddr, BAUD_CONTROL_OFS)) begin
               baudCtl_q[DATA_POL_BIT]  <= regWrData[DATA_POL_BIT];
               baudCtl_q[CLOCK_POL_BIT] <= regWrData[CLOCK_POL_BIT];
               baudCtl_q[DIV16_BIT]     <= regWrData[DIV16_BIT];
            end
            if (hit(regAddr, RECEIVE_STATUS_OFS)) begin
               rxCtl_q[PORT_ENABLE_BIT] <= regWrData[PORT_ENABLE_BIT];
               rxCtl_q[RX_NINE_BIT]     <= regWrData[RX_NINE_BIT];
               rxCtl_q[SINGLE_RX_BIT]   <= regWrData[SINGLE_RX_BIT];
               rxCtl_q[CONT_RX_BIT]     <= regWrData[CONT_RX_BIT];
            end
            if (hit(regAddr, TRANSMIT_STATUS_OFS)) begin
               txCtl_q[CLOCK_SOURCE_BIT]  <= regWrData[CLOCK_SOURCE_BIT];
               txCtl_q[TX_NINE_BIT]       <= regWrData[TX_NINE_BIT];
               txCtl_q[TX_ENABLE_BIT]     <= regWrData[TX_ENABLE_BIT];
               txCtl_q[SYNC_MODE_BIT]     <= regWrData[SYNC_MODE_BIT];
               txCtl_q[TX_NINTH_DATA_BIT] <= regWrData[TX_NINTH_DATA_BIT];
            end
            if (hit(regAddr, BAUD_DIV_LOW_OFS)) begin
               divLow_q <= regWrData;
            end
            if (hit(regAddr, BAUD_DIV_HIGH_OFS)) begin
               divHigh_q <= regWrData;
            end
            if (hit(regAddr, WAKE_CONTROL_OFS)) begin
               wakeCtl_q[PERIPH_IE_BIT] <= regWrData[PERIPH_IE_BIT];
               wakeCtl_q[TX_IE_BIT]     <= regWrData[TX_IE_BIT];
               wakeCtl_q[RX_IE_BIT]     <= regWrData[RX_IE_BIT];
            end
         end
      end
   end

   // host shift clock generator, idles at polarity level
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         baudCnt_q <= 16'h0000;
         ckPhase_q <= 1'b0;
         ckLevel_q <= 1'b0;
      end else if (!hostRun) begin
         baudCnt_q <= divisor;
         ckPhase_q <= 1'b0;
         ckLevel_q <= cpol;
      end else if (tick) begin
         baudCnt_q <= divisor;
         ckPhase_q <= !ckPhase_q;
         ckLevel_q <= ckPhase_q ? cpol : !cpol;
      end else begin
         baudCnt_q <= baudCnt_q - 16'h0001;
      end
   end

   // receive shift register; dropping the enable discards the partial
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rxShift_q <= 9'h000;
         rxCnt_q   <= 4'h0;
      end else if (!rxRun) begin
         rxCnt_q <= 4'h0;
      end else if (sample) begin
         rxShift_q <= rxNext;
         rxCnt_q   <= charDone ? 4'h0 : rxCnt_q + 4'h1;
      end
   end

   // two-entry receive fifo count
   always_comb begin
      fifoCount_d = fifoCount_q;
      if (push && !pop) begin
         fifoCount_d = fifoCount_q + 2'h1;
      end else if (pop && !push) begin
         fifoCount_d = fifoCount_q - 2'h1;
      end
   end

   // fifo storage and pointer
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         fifoCount_q <= 2'h0;
         rdPtr_q     <= 1'b0;
         fifoMem[0]  <= 9'h000;
         fifoMem[1]  <= 9'h000;
      end else if (!portOn) begin
         fifoCount_q <= 2'h0;
         rdPtr_q     <= 1'b0;
      end else begin
         if (push) begin
            fifoMem[rdPtr_q ^ fifoCount_q[0]] <= rxChar;
         end
         if (pop) begin
            rdPtr_q <= !rdPtr_q;
         end
         fifoCount_q <= fifoCount_d;
      end
   end

   // overrun error: set wins over every clear
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         overrun_error_q       <= 1'b0;
         oerrSingle_q <= 1'b0;
      end else if (overrunSet) begin
         overrun_error_q       <= 1'b1;
         oerrSingle_q <= rxCtl_q[SINGLE_RX_BIT] && !rxCtl_q[CONT_RX_BIT];
      end else if (!portOn) begin
         overrun_error_q <= 1'b0;
      end else if (oerrSingle_q && rcRead) begin
         overrun_error_q <= 1'b0;
      end else if (!oerrSingle_q && !rxCtl_q[CONT_RX_BIT]) begin
         overrun_error_q <= 1'b0;
      end
   end

   // transmit holding buffer and shift register
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         txBuf_q     <= REG_RESET;
         txBufFull_q <= 1'b0;
         tsr_q       <= 9'h000;
         txLeft_q    <= 4'h0;
         tsrBusy_q   <= 1'b0;
         dtOut_q     <= 1'b0;
      end else if (!portOn) begin
         txBufFull_q <= 1'b0;
         tsrBusy_q   <= 1'b0;
         txLeft_q    <= 4'h0;
         dtOut_q     <= dpol;
      end else begin
         if (!tsrBusy_q && txBufFull_q && txMode) begin
            tsr_q       <= {txCtl_q[TX_NINTH_DATA_BIT], txBuf_q};
            txLeft_q    <= nineTx ? BITS_NINE : BITS_EIGHT;
            tsrBusy_q   <= 1'b1;
            txBufFull_q <= 1'b0;
         end else if (tsrBusy_q && txMode && leadEdge && txLeft_q != 4'h0) begin
            dtOut_q  <= tsr_q[0] ^ dpol;
            tsr_q    <= {1'b0, tsr_q[8:1]};
            txLeft_q <= txLeft_q - 4'h1;
         end else if (tsrBusy_q && trailEdge && txLeft_q == 4'h0) begin
            tsrBusy_q <= 1'b0;
         end
         if (regWr && hit(regAddr, TRANSMIT_DATA_OFS)) begin
            txBuf_q     <= regWrData;
            txBufFull_q <= 1'b1;
         end
      end
   end

   // pin drivers, flags and wake request
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ckOe_n_q <= 1'b1;
         dtOe_n_q <= 1'b1;
         rxFlag_q <= 1'b0;
         txFlag_q <= 1'b0;
         wake_q   <= 1'b0;
      end else begin
         ckOe_n_q <= !hostMode;
         dtOe_n_q <= !txMode;
         rxFlag_q <= portOn && (fifoCount_d != 2'h0);
         txFlag_q <= portOn && !txBufFull_q;
         wake_q   <= wakeCtl_q[PERIPH_IE_BIT] &&
                     ((wakeCtl_q[TX_IE_BIT] && txFlag_q) ||
                      (wakeCtl_q[RX_IE_BIT] && rxFlag_q));
      end
   end

   // read data, valid the cycle after the strobe
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rdData_q <= REG_RESET;
      end else if (regRd) begin
         case (regAddr)
            BAUD_CONTROL_OFS:    rdData_q <= baudCtl_q | {1'b0, !rxRun, 6'h00};
            RECEIVE_DATA_OFS:    rdData_q <= fifoMem[rdPtr_q][7:0];
            RECEIVE_STATUS_OFS:  rdData_q <= {rxCtl_q[7:4], 2'h0, overrun_error_q,
                                              fifoMem[rdPtr_q][8]};
            BAUD_DIV_LOW_OFS:    rdData_q <= divLow_q;
            BAUD_DIV_HIGH_OFS:   rdData_q <= divHigh_q;
            TRANSMIT_STATUS_OFS: rdData_q <= {txCtl_q[7:4], 2'h0, !tsrBusy_q,
                                              txCtl_q[TX_NINTH_DATA_BIT]};
            WAKE_CONTROL_OFS:    rdData_q <= {2'h0, rxFlag_q, txFlag_q, 1'b0,
                                              wakeCtl_q[2:0]};
            default:             rdData_q <= REG_RESET;
         endcase
      end else begin
         rdData_q <= REG_RESET;
      end
   end

   assign regRdData    = rdData_q;
   assign dataOut      = dtOut_q;
   assign dataOe_n     = dtOe_n_q;
   assign clockOut     = ckLevel_q;
   assign clockOe_n    = ckOe_n_q;
   assign receiveFlag  = rxFlag_q;
   assign transmitFlag = txFlag_q;
   assign wakeRequest  = wake_q;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence seqTxQueued;
      regWr && hit(regAddr, TRANSMIT_DATA_OFS) && tsrBusy_q && portOn;
   endsequence
   sequence seqSingleOverrun;
      overrun_error_q && oerrSingle_q && rcRead && !overrunSet && portOn;
   endsequence

   AST_FLAG_FOLLOWS_FIFO: assert property (
      receiveFlag == (fifoCount_q != 2'h0))
      else $error("receive flag disagrees with fifo fill");
   AST_OVERRUN_ONLY_FULL: assert property (
      overrunSet |=> overrun_error_q && fifoCount_q == $past(fifoCount_d) &&
                     fifoMem[0] == $past(fifoMem[0]) && fifoMem[1] == $past(fifoMem[1]))
      else $error("overrun altered fifo contents");
   AST_NO_ACCEPT_IN_OVERRUN: assert property (
      (overrun_error_q && !pop) |=> fifoCount_q == $past(fifoCount_q) || !$past(portOn))
      else $error("character accepted during overrun");
   AST_SINGLE_OVERRUN_READ: assert property (
      seqSingleOverrun |=> !overrun_error_q)
      else $error("single-mode overrun not cleared by read");
   AST_CONT_OVERRUN_HOLDS: assert property (
      (overrun_error_q && !oerrSingle_q && rxCtl_q[CONT_RX_BIT] && portOn) |=> overrun_error_q)
      else $error("continuous overrun cleared too early");
   AST_CLOCK_IDLES_STOPPED: assert property (
      (hostMode && !rxReq && !txRun) |=> clockOut == $past(cpol))
      else $error("host clock not idle after receive stopped");
   AST_SINGLE_SELF_CLEAR: assert property (
      (hostMode && charDone && !(regWr && hit(regAddr, RECEIVE_STATUS_OFS)))
      |=> !rxCtl_q[SINGLE_RX_BIT])
      else $error("single receive not cleared after character");
   AST_SECOND_WORD_WAITS: assert property (
      seqTxQueued |=> ##1 !transmitFlag)
      else $error("transmit flag set while second word waits");
   AST_WAKE_ON_TX: assert property (
      (transmitFlag && wakeCtl_q[PERIPH_IE_BIT] && wakeCtl_q[TX_IE_BIT]) |=> wakeRequest)
      else $error("enabled transmit flag raised no wake request");
   AST_CLIENT_CLOCK_RELEASED: assert property (
      clientMode |=> clockOe_n)
      else $error("client drives the shift clock");
endmodule
